// ---- inc/flash_row_regs.svh ----
// Register offsets, field positions, widths and reset values of the row write sequencer.
// Included by the package and by every design file that needs the numbers.
`ifndef FLASH_ROW_REGS_SVH
`define FLASH_ROW_REGS_SVH

// Register byte offsets (low address byte)
`define FRW_OFS_ADDR_LOW 8'h00
`define FRW_OFS_ADDR_HIGH 8'h04
`define FRW_OFS_WDATA_LOW 8'h08
`define FRW_OFS_WDATA_HIGH 8'h0c
`define FRW_OFS_CONTROL 8'h10
`define FRW_OFS_UNLOCK 8'h14
`define FRW_OFS_W 8

// Control register bit positions
`define FRW_CTRL_ERASE_BIT 0
`define FRW_CTRL_START_BIT 1
`define FRW_CTRL_PERMIT_BIT 2
`define FRW_CTRL_LATCH_ONLY_BIT 5
`define FRW_CTRL_REGION_BIT 6

// Geometry
`define FRW_LATCHES 32
`define FRW_IDX_W 5
`define FRW_ROW_W 10
`define FRW_WORD_W 14
`define FRW_ADDR_W 15
`define FRW_ADRH_W 7
`define FRW_ADRL_W 8
`define FRW_DATH_W 6
`define FRW_DATL_W 8
`define FRW_KEY_W 8

// Values
`define FRW_BLANK_WORD 14'h3fff
`define FRW_KEY_FIRST 8'h5a
`define FRW_KEY_SECOND 8'hc3
`define FRW_HTRANS_ACTIVE_BIT 1
`define FRW_HRESP_OKAY 1'b0

`endif

// ---- inc/flash_row_pkg.sv ----
// Types shared by the row write sequencer and its latch bank.
// Assumes flash_row_regs.svh on the include path.
`include "flash_row_regs.svh"
package flash_row_pkg;

   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_PROG = 2'b01,
      OP_ERASE = 2'b10
   } flash_op_t;

   typedef struct packed {
      flash_op_t op;
      logic [`FRW_ADDR_W-1:0] addr;
      logic [`FRW_WORD_W-1:0] data;
   } flash_cmd_t;

   typedef struct packed {
      logic region_select;
      logic latch_only_load;
      logic write_permit;
      logic row_erase;
   } mem_ctrl_t;

   typedef enum logic [2:0] {
      UL_IDLE = 3'b001,
      UL_HALF = 3'b010,
      UL_ARMED = 3'b100
   } unlock_state_t;

   typedef enum logic [3:0] {
      SQ_IDLE = 4'b0001,
      SQ_ISSUE = 4'b0010,
      SQ_WAIT = 4'b0100,
      SQ_CLEAR = 4'b1000
   } seq_state_t;

endpackage

// ---- hdl/flash_row_latch_bank.sv ----
// Bank of word-wide write latches for one flash row.
// Assumes load and clear come from the sequencer on the same clock.
`timescale 1ns/1ps
`include "flash_row_regs.svh"
module flash_row_latch_bank
   import flash_row_pkg::*;
#(
   parameter int LATCHES = `FRW_LATCHES,
   parameter int IDX_W = `FRW_IDX_W
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Load and clear
   input wire logic load_en,
   input wire logic [IDX_W-1:0] load_idx,
   input wire logic [`FRW_WORD_W-1:0] load_data,
   input wire logic clear_all,
   // Read
   input wire logic [IDX_W-1:0] rd_idx,
   output logic [`FRW_WORD_W-1:0] rd_data,
   output logic all_blank
);

   logic [`FRW_WORD_W-1:0] latch_ff [LATCHES];
   logic [LATCHES-1:0] blank_vec;

   for (genvar i = 0; i < LATCHES; i++) begin : g_latch
      always_ff @(posedge sys_clk) begin
         if (!nrst || clear_all) begin
            latch_ff[i] <= `FRW_BLANK_WORD;
         end else if (load_en && load_idx == IDX_W'(i)) begin
            latch_ff[i] <= load_data;
         end
      end
      assign blank_vec[i] = (latch_ff[i] == `FRW_BLANK_WORD);
   end

   assign rd_data = latch_ff[rd_idx];
   assign all_blank = &blank_vec;

endmodule

// ---- hdl/flash_row_write_latch_seq.sv ----
// Row write sequencer for program flash: AHB-Lite register slave, unlock check, latch bank, command stream.
// Assumes one AHB-Lite master, single word transfers, and a flash array that acks each command on sys_clk.
`timescale 1ns/1ps
`include "flash_row_regs.svh"
module flash_row_write_latch_seq
   import flash_row_pkg::*;
#(
   parameter int LATCHES = `FRW_LATCHES,
   parameter logic [`FRW_KEY_W-1:0] KEY_FIRST = `FRW_KEY_FIRST,
   parameter logic [`FRW_KEY_W-1:0] KEY_SECOND = `FRW_KEY_SECOND
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Flash array command port
   output flash_cmd_t flash_cmd,
   output logic flash_cmd_valid,
   input wire logic flash_cmd_ack,
   // Status
   output logic seq_busy
);

   localparam int IDX_W = `FRW_IDX_W;

   // Bus state
   logic addr_acc;
   logic wr_pend_ff;
   logic [`FRW_OFS_W-1:0] wr_ofs_ff;
   logic [31:0] hrdata_ff;
   logic hreadyout_ff;
   logic hresp_ff;
   logic wr_now;

   // Software registers
   logic [`FRW_ADRL_W-1:0] adrl_ff;
   logic [`FRW_ADRH_W-1:0] adrh_ff;
   logic [`FRW_DATL_W-1:0] datl_ff;
   logic [`FRW_DATH_W-1:0] dath_ff;
   mem_ctrl_t ctrl_ff;
   mem_ctrl_t ctrl_w;

   // Unlock and sequencing
   unlock_state_t ul_state_ff;
   unlock_state_t nxt_ul_state;
   seq_state_t sq_state_ff;
   logic key_wr;
   logic start_wr;
   logic trigger;
   logic latch_load;
   logic [`FRW_ROW_W-1:0] row_ff;
   flash_op_t op_ff;
   logic [IDX_W-1:0] word_idx_ff;
   logic busy_ff;
   flash_cmd_t cmd_ff;
   logic cmd_valid_ff;
   logic [`FRW_WORD_W-1:0] latch_rd;
   logic all_blank;
   logic [IDX_W:0] words_cnt_ff;

   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = hresp_ff;
   assign flash_cmd = cmd_ff;
   assign flash_cmd_valid = cmd_valid_ff;
   assign seq_busy = busy_ff;

   // Address phase capture; zero wait states, so the data phase is one cycle
   assign addr_acc = hsel && hready && htrans[`FRW_HTRANS_ACTIVE_BIT];
   assign wr_now = wr_pend_ff;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wr_pend_ff <= 1'b0;
         wr_ofs_ff <= '0;
         hreadyout_ff <= 1'b0;
         hresp_ff <= `FRW_HRESP_OKAY;
      end else begin
         wr_pend_ff <= addr_acc && hwrite;
         if (addr_acc) begin
            wr_ofs_ff <= haddr[`FRW_OFS_W-1:0];
         end
         hreadyout_ff <= 1'b1;
         hresp_ff <= `FRW_HRESP_OKAY;
      end
   end

   // Read data prepared at the address phase, unmapped offsets read zero
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         hrdata_ff <= '0;
      end else if (addr_acc && !hwrite) begin
         hrdata_ff <= '0;
         unique case (haddr[`FRW_OFS_W-1:0])
            `FRW_OFS_ADDR_LOW: hrdata_ff[`FRW_ADRL_W-1:0] <= adrl_ff;
            `FRW_OFS_ADDR_HIGH: hrdata_ff[`FRW_ADRH_W-1:0] <= adrh_ff;
            `FRW_OFS_WDATA_LOW: hrdata_ff[`FRW_DATL_W-1:0] <= datl_ff;
            `FRW_OFS_WDATA_HIGH: hrdata_ff[`FRW_DATH_W-1:0] <= dath_ff;
            `FRW_OFS_CONTROL: begin
               hrdata_ff[`FRW_CTRL_ERASE_BIT] <= ctrl_ff.row_erase;
               hrdata_ff[`FRW_CTRL_START_BIT] <= busy_ff;
               hrdata_ff[`FRW_CTRL_PERMIT_BIT] <= ctrl_ff.write_permit;
               hrdata_ff[`FRW_CTRL_LATCH_ONLY_BIT] <= ctrl_ff.latch_only_load;
               hrdata_ff[`FRW_CTRL_REGION_BIT] <= ctrl_ff.region_select;
            end
            default: hrdata_ff <= '0;
         endcase
      end
   end

   // Address and data register pairs
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         adrl_ff <= '0;
         adrh_ff <= '0;
         datl_ff <= '0;
         dath_ff <= '0;
      end else if (wr_now) begin
         if (wr_ofs_ff == `FRW_OFS_ADDR_LOW) begin
            adrl_ff <= hwdata[`FRW_ADRL_W-1:0];
         end
         if (wr_ofs_ff == `FRW_OFS_ADDR_HIGH) begin
            adrh_ff <= hwdata[`FRW_ADRH_W-1:0];
         end
         if (wr_ofs_ff == `FRW_OFS_WDATA_LOW) begin
            datl_ff <= hwdata[`FRW_DATL_W-1:0];
         end
         if (wr_ofs_ff == `FRW_OFS_WDATA_HIGH) begin
            dath_ff <= hwdata[`FRW_DATH_W-1:0];
         end
      end
   end

   // Control bits as written in this data phase
   always_comb begin
      ctrl_w.row_erase = hwdata[`FRW_CTRL_ERASE_BIT];
      ctrl_w.write_permit = hwdata[`FRW_CTRL_PERMIT_BIT];
      ctrl_w.latch_only_load = hwdata[`FRW_CTRL_LATCH_ONLY_BIT];
      ctrl_w.region_select = hwdata[`FRW_CTRL_REGION_BIT];
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_ff <= '0;
      end else if (wr_now && wr_ofs_ff == `FRW_OFS_CONTROL) begin
         ctrl_ff <= ctrl_w;
      end
   end

   // Unlock: two key writes then the start write, with no other access between
   assign key_wr = wr_now && wr_ofs_ff == `FRW_OFS_UNLOCK;
   assign start_wr = wr_now && wr_ofs_ff == `FRW_OFS_CONTROL && hwdata[`FRW_CTRL_START_BIT];

   always_comb begin
      nxt_ul_state = ul_state_ff;
      if (wr_now) begin
         if (key_wr && hwdata[`FRW_KEY_W-1:0] == KEY_FIRST) begin
            nxt_ul_state = UL_HALF;
         end else if (key_wr && ul_state_ff == UL_HALF && hwdata[`FRW_KEY_W-1:0] == KEY_SECOND) begin
            nxt_ul_state = UL_ARMED;
         end else begin
            nxt_ul_state = UL_IDLE;
         end
      end
      if (addr_acc && !hwrite) begin
         nxt_ul_state = UL_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ul_state_ff <= UL_IDLE;
      end else begin
         ul_state_ff <= nxt_ul_state;
      end
   end

   // Start accepted only when armed, permitted, program region, and idle
   assign trigger = start_wr && ul_state_ff == UL_ARMED
                    && ctrl_w.write_permit
                    && !ctrl_w.region_select
                    && sq_state_ff == SQ_IDLE;
   assign latch_load = trigger && !ctrl_w.row_erase;

   flash_row_latch_bank #(
      .LATCHES(LATCHES),
      .IDX_W(IDX_W)
   ) u_bank (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .load_en(latch_load),
      .load_idx(adrl_ff[IDX_W-1:0]),
      .load_data({dath_ff, datl_ff}),
      .clear_all(sq_state_ff == SQ_CLEAR),
      .rd_idx(word_idx_ff),
      .rd_data(latch_rd),
      .all_blank(all_blank)
   );

   // Operation sequencer
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         sq_state_ff <= SQ_IDLE;
         row_ff <= '0;
         op_ff <= OP_NONE;
         word_idx_ff <= '0;
         busy_ff <= 1'b0;
      end else begin
         unique case (sq_state_ff)
            SQ_IDLE: begin
               if (trigger && (ctrl_w.row_erase || !ctrl_w.latch_only_load)) begin
                  row_ff <= {adrh_ff, adrl_ff[`FRW_ADRL_W-1:IDX_W]};
                  op_ff <= ctrl_w.row_erase ? OP_ERASE : OP_PROG;
                  word_idx_ff <= '0;
                  busy_ff <= 1'b1;
                  sq_state_ff <= SQ_ISSUE;
               end
            end
            SQ_ISSUE: sq_state_ff <= SQ_WAIT;
            SQ_WAIT: begin
               if (flash_cmd_ack) begin
                  if (op_ff == OP_PROG && word_idx_ff != IDX_W'(LATCHES - 1)) begin
                     word_idx_ff <= word_idx_ff + 1'b1;
                     sq_state_ff <= SQ_ISSUE;
                  end else begin
                     sq_state_ff <= SQ_CLEAR;
                  end
               end
            end
            SQ_CLEAR: begin
               busy_ff <= 1'b0;
               op_ff <= OP_NONE;
               sq_state_ff <= SQ_IDLE;
            end
         endcase
      end
   end

   // Command to the array, held until acknowledged
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cmd_ff <= '0;
         cmd_valid_ff <= 1'b0;
      end else if (sq_state_ff == SQ_ISSUE) begin
         cmd_valid_ff <= 1'b1;
         cmd_ff.op <= op_ff;
         if (op_ff == OP_ERASE) begin
            cmd_ff.addr <= {row_ff, IDX_W'(0)};
            cmd_ff.data <= `FRW_BLANK_WORD;
         end else begin
            cmd_ff.addr <= {row_ff, word_idx_ff};
            cmd_ff.data <= latch_rd;
         end
      end else if (sq_state_ff == SQ_WAIT && flash_cmd_ack) begin
         cmd_valid_ff <= 1'b0;
      end
   end

   // Programming words issued in the current operation
   always_ff @(posedge sys_clk) begin
      if (!nrst || sq_state_ff == SQ_IDLE) begin
         words_cnt_ff <= '0;
      end else if (sq_state_ff == SQ_ISSUE && op_ff == OP_PROG) begin
         words_cnt_ff <= words_cnt_ff + 1'b1;
      end
   end

   // Checks
   sequence s_armed_start;
      start_wr && ul_state_ff == UL_ARMED && sq_state_ff == SQ_IDLE && ctrl_w.write_permit
         && !ctrl_w.region_select;
   endsequence

   sequence s_prog_begin;
      sq_state_ff == SQ_ISSUE ##1 cmd_valid_ff && cmd_ff.op == OP_PROG && cmd_ff.addr[IDX_W-1:0] == '0;
   endsequence

   a_load_needs_unlock: assert property (@(posedge sys_clk) disable iff (!nrst)
      latch_load |-> ul_state_ff == UL_ARMED && start_wr)
      else $error("latch loaded without unlock");

   a_broken_unlock: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ul_state_ff == UL_HALF && ((wr_now && !key_wr) || (addr_acc && !hwrite)))
         |=> ul_state_ff == UL_IDLE ##1 !latch_load)
      else $error("interrupted unlock still armed");

   a_latch_only_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
      (s_armed_start and ##0 (ctrl_w.latch_only_load && !ctrl_w.row_erase))
      |-> latch_load ##1 (sq_state_ff == SQ_IDLE && !cmd_valid_ff) [*3])
      else $error("latch-only load started programming");

   a_commit_starts: assert property (@(posedge sys_clk) disable iff (!nrst)
      (s_armed_start and ##0 (!ctrl_w.latch_only_load && !ctrl_w.row_erase)) |-> latch_load ##1 s_prog_begin)
      else $error("row commit did not start programming");

   a_prog_not_erase: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cmd_valid_ff && op_ff == OP_PROG) |-> cmd_ff.op == OP_PROG)
      else $error("erase issued during programming");

   a_erase_whole_row: assert property (@(posedge sys_clk) disable iff (!nrst)
      (cmd_valid_ff && cmd_ff.op == OP_ERASE) |-> cmd_ff.addr[IDX_W-1:0] == '0 && sq_state_ff != SQ_ISSUE
         && (!$past(cmd_valid_ff) || $stable(cmd_ff)))
      else $error("erase not row aligned");

   a_word_limit: assert property (@(posedge sys_clk) disable iff (!nrst)
      words_cnt_ff <= (IDX_W + 1)'(LATCHES))
      else $error("more words than latches");

   a_all_words: assert property (@(posedge sys_clk) disable iff (!nrst)
      (sq_state_ff == SQ_CLEAR && op_ff == OP_PROG) |-> words_cnt_ff == (IDX_W + 1)'(LATCHES))
      else $error("row commit skipped latches");

   a_row_confined: assert property (@(posedge sys_clk) disable iff (!nrst)
      cmd_valid_ff |-> cmd_ff.addr[`FRW_ADDR_W-1:IDX_W] == row_ff && $stable(row_ff))
      else $error("command outside addressed row");

   a_blank_after: assert property (@(posedge sys_clk) disable iff (!nrst)
      sq_state_ff == SQ_CLEAR |=> all_blank && !busy_ff)
      else $error("latches not blank after operation");

   a_permit_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
      (start_wr && !ctrl_w.write_permit) |-> !latch_load ##1 !$rose(busy_ff))
      else $error("start accepted without write permit");

   a_busy_ignore: assert property (@(posedge sys_clk) disable iff (!nrst)
      (start_wr && busy_ff) |-> !latch_load ##1 $stable(row_ff))
      else $error("trigger taken while busy");

   a_load_data: assert property (@(posedge sys_clk) disable iff (!nrst)
      (latch_load && ctrl_w.latch_only_load && adrl_ff[IDX_W-1:0] == word_idx_ff)
         |=> latch_rd == $past({dath_ff, datl_ff}))
      else $error("latch data not high:low pair");

   a_row_from_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
      (trigger && !ctrl_w.latch_only_load) |=> row_ff == $past({adrh_ff, adrl_ff[`FRW_ADRL_W-1:IDX_W]}))
      else $error("row not taken from address bits");

endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the flash row write sequencer: bus tasks, row model, command check.
// Assumes the design package and register header on the include path; bench acks the array port.
`timescale 1ns/1ps
`include "flash_row_regs.svh"
module tb_top
   import flash_row_pkg::*;
;
   localparam logic [7:0] K1 = 8'h96;
   localparam logic [7:0] K2 = 8'h3c;
   localparam int PRM = 1 << `FRW_CTRL_PERMIT_BIT;
   localparam int LO = 1 << `FRW_CTRL_LATCH_ONLY_BIT;
   localparam int ERS = 1 << `FRW_CTRL_ERASE_BIT;
   localparam int RGN = 1 << `FRW_CTRL_REGION_BIT;
   localparam int STRT = 1 << `FRW_CTRL_START_BIT;
   logic sys_clk;
   logic nrst;
   logic hsel;
   logic hwrite;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic flash_cmd_ack;
   logic flash_cmd_valid;
   logic seq_busy;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   flash_cmd_t flash_cmd;
   int mismatches;
   int compares;
   int cyc;
   int alo;
   int ahi;
   int dlo;
   int dhi;
   int mbusy;
   int row;
   int k;
   int lat[32];
   logic [30:0] expq[$];

   // Single slave: its ready is the bus ready
   assign hready = hreadyout;

   flash_row_write_latch_seq #(.LATCHES(32), .KEY_FIRST(K1), .KEY_SECOND(K2)) u_flash_row_write_latch_seq (
      .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .flash_cmd(flash_cmd), .flash_cmd_valid(flash_cmd_valid),
      .flash_cmd_ack(flash_cmd_ack), .seq_busy(seq_busy));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // One single AHB-Lite transfer; read data lands in q
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hready !== 1'b1 && n < 40);
      htrans <= 2'b00;
      hwdata <= d;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hready !== 1'b1 && n < 40);
      q = hrdata;
      hsel <= 1'b0;
   endtask

   task automatic setw(input int r, input int idx, input int w);
      ahi = r >> 3;
      alo = ((r & 7) << 5) | idx;
      dhi = w >> 8;
      dlo = w & 8'hff;
      bus(1'b1, `FRW_OFS_ADDR_HIGH, ahi);
      bus(1'b1, `FRW_OFS_ADDR_LOW, alo);
      bus(1'b1, `FRW_OFS_WDATA_HIGH, dhi);
      bus(1'b1, `FRW_OFS_WDATA_LOW, dlo);
   endtask

   // Unlock and start, with the row model deciding what must follow
   task automatic go(input int ctrl, input logic [7:0] k1, input bit brk);
      int r;
      int idx;
      int w;
      bus(1'b1, `FRW_OFS_UNLOCK, k1);
      if (brk) bus(1'b0, `FRW_OFS_ADDR_LOW, 0);
      bus(1'b1, `FRW_OFS_UNLOCK, K2);
      bus(1'b1, `FRW_OFS_CONTROL, ctrl | STRT);
      r = (ahi << 3) | (alo >> 5);
      idx = alo & 31;
      w = (dhi << 8) | dlo;
      if (k1 == K1 && !brk && (ctrl & PRM) && !(ctrl & RGN) && !mbusy) begin
         if (ctrl & ERS) begin
            expq.push_back({OP_ERASE, r[9:0], 5'd0, 14'h3fff});
            foreach (lat[i]) lat[i] = 'h3fff;
            mbusy = 1;
         end else begin
            lat[idx] = w;
            if (!(ctrl & LO)) begin
               for (int j = 0; j < 32; j++) expq.push_back({OP_PROG, r[9:0], j[4:0], lat[j][13:0]});
               foreach (lat[i]) lat[i] = 'h3fff;
               mbusy = 1;
            end
         end
      end
      #1 check(seq_busy, mbusy[0]);
      repeat (3) @(posedge sys_clk);
      #1 check(flash_cmd_valid, expq.size() > 0);
   endtask

   // Accept every expected command at a random pace
   task automatic drain();
      int n;
      logic [30:0] e;
      while (expq.size() > 0) begin
         e = expq.pop_front();
         n = 0;
         #1;
         while (flash_cmd_valid !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1 n++;
         end
         repeat ($urandom_range(3)) @(posedge sys_clk);
         #1 check({flash_cmd_valid, flash_cmd}, {1'b1, e});
         @(posedge sys_clk);
         flash_cmd_ack <= 1'b1;
         @(posedge sys_clk);
         flash_cmd_ack <= 1'b0;
      end
      n = 0;
      while (seq_busy !== 1'b0 && n < 10) begin
         @(posedge sys_clk);
         #1 n++;
      end
      check(seq_busy, 1'b0);
      check(flash_cmd_valid, 1'b0);
      mbusy = 0;
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         complete_run();
      end
   end

   initial begin
      void'($urandom(27891));
      nrst = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      flash_cmd_ack = 1'b0;
      mismatches = 0;
      compares = 0;
      cyc = 0;
      mbusy = 0;
      foreach (lat[i]) lat[i] = 'h3fff;
      repeat (8) @(posedge sys_clk);
      #1 check(hreadyout, 1'b0);
      check(flash_cmd_valid, 1'b0);
      check(seq_busy, 1'b0);
      @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      // Reset values, unmapped and write-only places
      bus(1'b0, `FRW_OFS_CONTROL, 0);
      check(q, 32'h0);
      bus(1'b1, 8'h18, 32'hffffffff);
      bus(1'b0, 8'h18, 0);
      check(q, 32'h0);
      bus(1'b0, `FRW_OFS_UNLOCK, 0);
      check(q, 32'h0);
      bus(1'b1, `FRW_OFS_ADDR_HIGH, 32'hffffffff);
      bus(1'b0, `FRW_OFS_ADDR_HIGH, 0);
      check(q, 32'h7f);
      check(hresp, 1'b0);
      // Fill part of a row, with refused attempts mixed in, then commit it
      row = $urandom_range(1023);
      for (k = 0; k < 6; k++) begin
         setw(row, $urandom_range(31), $urandom_range(16383));
         go(PRM | LO, K1, 1'b0);
      end
      setw(row, 7, $urandom_range(16383));
      go(PRM | LO, K1, 1'b1);
      setw(row, 8, $urandom_range(16383));
      go(PRM | LO, `FRW_KEY_FIRST, 1'b0);
      setw(row, 9, $urandom_range(16383));
      go(LO, K1, 1'b0);
      setw(row, 10, $urandom_range(16383));
      go(PRM | LO | RGN, K1, 1'b0);
      setw(row, 31, $urandom_range(16383));
      go(PRM, K1, 1'b0);
      bus(1'b0, `FRW_OFS_CONTROL, 0);
      check(q[1], 1'b1);
      setw(row ^ 1, 3, $urandom_range(16383));
      go(PRM | LO, K1, 1'b0);
      drain();
      // Neighbour row with a single loaded word
      setw(row ^ 1, 31, $urandom_range(16383));
      go(PRM, K1, 1'b0);
      drain();
      // Erase wipes a loaded latch
      setw(row, 31, $urandom_range(16383));
      go(PRM | LO, K1, 1'b0);
      go(PRM | ERS, K1, 1'b0);
      drain();
      setw(row, 0, $urandom_range(16383));
      go(PRM, K1, 1'b0);
      drain();
      complete_run();
   end
endmodule
